// >>> emtm_pkg.sv
// shared constants and types of the emulator trace and memory map block
package emtm_pkg;
  // ==================================================================
  // trace buffer geometry
  localparam int TRACE_DEPTH = 255;          // records held
  localparam int PTR_W = 8;                  // trace pointer width
  localparam logic [7:0] PTR_LAST = 8'hfe;   // index of last entry
  localparam logic [7:0] PTR_ZERO = 8'h00;   // first entry
  localparam logic [7:0] COUNT_FULL = 8'hff; // record count when full
  localparam int REC_W = 44;                 // bits per record
  // ==================================================================
  // memory map geometry
  localparam int PC_W = 12;                  // program address width
  localparam int BLK_MSB = 11;               // block select msb
  localparam int BLK_LSB = 8;                // block select lsb
  localparam int PROG_BLOCKS = 16;           // program blocks
  localparam int PROG_BYTES = 4096;          // full program space
  localparam int DATA_BYTES = 512;           // internal plus external data
  localparam logic IDX_INT = 1'b0;           // internal data half
  localparam logic IDX_EXT = 1'b1;           // external data half
  // emulated clock ceiling, all work is single cycle at core rate
  localparam int EMU_CLK_MHZ = 11;
  // ==================================================================
  // host access spaces
  localparam logic [1:0] SPACE_PROG = 2'h0;
  localparam logic [1:0] SPACE_EXT = 2'h1;
  localparam logic [1:0] SPACE_INT = 2'h2;
  // ==================================================================
  // one trace record, 44 bits
  typedef struct packed {
    logic [11:0] pc;    // program counter
    logic [7:0] instr;  // executed opcode
    logic [7:0] busp;   // bus port value
    logic [7:0] p1;     // port 1 value
    logic [3:0] p2lo;   // port 2 low nibble
    logic [3:0] stat;   // selected status lines
  } emtm_cyc_t;
  // host access to emulator memory through the shared region
  typedef struct packed {
    logic wr;           // write strobe
    logic rd;           // read strobe
    logic [1:0] space;  // target space
    logic [11:0] addr;  // byte address
    logic [7:0] wdata;  // write data
  } emtm_host_t;
  // host commands
  typedef enum logic [1:0] {EMTM_CMD_NONE, EMTM_CMD_GO, EMTM_CMD_STEP, EMTM_CMD_STOP} emtm_cmd_t;
  // run control states
  typedef enum logic [1:0] {EMTM_IDLE, EMTM_RUN, EMTM_STEP} emtm_state_t;
endpackage

// >>> emtm_core.sv
// emulator trace buffer, cycle counter, run control and memory map
`timescale 1ns/1ns
`default_nettype none
module emtm_core
  import emtm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // emulated processor cycle stream
  input wire logic cyc_stb,
  input wire emtm_cyc_t cyc_rec,
  input wire logic error_in,
  // program fetch
  input wire logic fetch_stb,
  input wire logic [11:0] fetch_addr,
  output logic [7:0] prog_rdata_q,
  output logic prog_emu_q,
  // external data space access
  input wire logic x_rd,
  input wire logic x_wr,
  input wire logic [7:0] x_addr,
  input wire logic [7:0] x_wdata,
  output logic [7:0] x_rdata_q,
  output logic x_emu_q,
  // internal data access
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] i_rdata_q,
  // map and breakpoint setup
  input wire logic [15:0] prog_map,
  input wire logic ext_map,
  input wire logic brk_pc_en,
  input wire logic [11:0] brk_pc,
  input wire logic brk_x_en,
  input wire logic [7:0] brk_xaddr,
  // host command and shared memory port
  input wire emtm_cmd_t host_cmd,
  input wire emtm_host_t host_acc,
  input wire logic cnt_clr,
  output logic [7:0] host_rdata_q,
  output logic host_ack_q,
  // status and trace readback
  input wire logic [7:0] trace_idx,
  output logic [43:0] trace_data_q,
  output logic [7:0] newest_q,
  output logic [7:0] count_q,
  output logic [CNT_W-1:0] cyc_cnt_q,
  output logic running_q,
  output logic brk_hit_q
);
  // ==================================================================
  // storage, flip-flops addressed by index
  logic [REC_W-1:0] trace_mem [0:TRACE_DEPTH-1]; // trace records
  logic [7:0] prog_mem [0:PROG_BYTES-1];         // program replacement
  logic [7:0] data_mem [0:DATA_BYTES-1];         // internal and external
  emtm_state_t state_q, state_d;                 // run control
  logic [7:0] wr_ptr_q, wr_ptr_d;                // next trace slot
  logic [7:0] newest_d, count_d;
  logic [CNT_W-1:0] cyc_cnt_d;
  logic running_d, brk_hit_d;
  logic active, trace_we, pc_match, x_match, stop_now;
  logic host_ok, host_pwe, host_dwe, x_emu_we;
  logic [REC_W-1:0] rec_bits;

  // ==================================================================
  // checks share one clock and the reset for the whole module
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==================================================================
  // run control and breakpoint comparators
  always_comb begin
    active = (state_q != EMTM_IDLE);
    pc_match = brk_pc_en && cyc_stb && (cyc_rec.pc == brk_pc);
    x_match = brk_x_en && x_wr && (x_addr == brk_xaddr);
    stop_now = active && (pc_match || x_match || error_in || host_cmd == EMTM_CMD_STOP);
    state_d = state_q;
    brk_hit_d = active && (pc_match || x_match);
    case (state_q)
      // idle: accept start commands
      EMTM_IDLE: begin
        if (host_cmd == EMTM_CMD_GO) begin
          state_d = EMTM_RUN;
        end else if (host_cmd == EMTM_CMD_STEP) begin
          state_d = EMTM_STEP;
        end
      end
      // free running until a stop cause
      EMTM_RUN: begin
        if (stop_now) begin
          state_d = EMTM_IDLE;
        end
      end
      EMTM_STEP: begin
        if (stop_now || cyc_stb) begin
          state_d = EMTM_IDLE;
        end
      end
      default: begin
        state_d = EMTM_IDLE;
      end
    endcase
    running_d = (state_d != EMTM_IDLE);
  end

  // ==================================================================
  // trace pointer, count and cycle counter
  always_comb begin
    // one write per executed cycle while running
    trace_we = active && cyc_stb;
    rec_bits = cyc_rec;
    wr_ptr_d = wr_ptr_q;
    newest_d = newest_q;
    count_d = count_q;
    cyc_cnt_d = cyc_cnt_q;
    if (trace_we) begin
      newest_d = wr_ptr_q;
      wr_ptr_d = (wr_ptr_q == PTR_LAST) ? PTR_ZERO : wr_ptr_q + 8'h01;
      count_d = (count_q == COUNT_FULL) ? COUNT_FULL : count_q + 8'h01;
      cyc_cnt_d = cyc_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (cnt_clr) begin
      cyc_cnt_d = '0;
    end
  end

  // ==================================================================
  // host and processor memory write enables
  always_comb begin
    host_ok = !active;
    host_pwe = host_ok && host_acc.wr && (host_acc.space == SPACE_PROG);
    host_dwe = host_ok && host_acc.wr && (host_acc.space != SPACE_PROG);
    // external writes land in emulator ram only when mapped
    x_emu_we = active && x_wr && ext_map;
  end

  // ==================================================================
  // control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= EMTM_IDLE;
      wr_ptr_q <= PTR_ZERO;
      newest_q <= PTR_ZERO;
      count_q <= PTR_ZERO;
      cyc_cnt_q <= '0;
      running_q <= 1'b0;
      brk_hit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wr_ptr_q <= wr_ptr_d;
      newest_q <= newest_d;
      count_q <= count_d;
      cyc_cnt_q <= cyc_cnt_d;
      running_q <= running_d;
      brk_hit_q <= brk_hit_d;
    end
  end

  // ==================================================================
  // storage writes, no reset on memories
  always_ff @(posedge core_clk) begin
    if (trace_we) begin
      trace_mem[wr_ptr_q] <= rec_bits;
    end
    if (host_pwe) begin
      prog_mem[host_acc.addr] <= host_acc.wdata;
    end
    // 512 bytes, internal half then external half
    if (host_dwe) begin
      data_mem[{host_acc.space == SPACE_EXT, host_acc.addr[7:0]}] <= host_acc.wdata;
    end
    if (active && i_wr) begin
      data_mem[{IDX_INT, i_addr}] <= i_wdata;
    end
    if (x_emu_we) begin
      data_mem[{IDX_EXT, x_addr}] <= x_wdata;
    end
  end

  // ==================================================================
  // read paths, one cycle each
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prog_rdata_q <= 8'h00;
      prog_emu_q <= 1'b0;
      x_rdata_q <= 8'h00;
      x_emu_q <= 1'b0;
      i_rdata_q <= 8'h00;
      host_rdata_q <= 8'h00;
      host_ack_q <= 1'b0;
      trace_data_q <= '0;
    end else begin
      // fetch answered next cycle, no wait state
      if (fetch_stb) begin
        prog_rdata_q <= prog_mem[fetch_addr];
        prog_emu_q <= prog_map[fetch_addr[BLK_MSB:BLK_LSB]];
      end
      if (x_rd || x_wr) begin
        x_rdata_q <= data_mem[{IDX_EXT, x_addr}];
        x_emu_q <= ext_map;
      end
      i_rdata_q <= data_mem[{IDX_INT, i_addr}];
      host_ack_q <= host_ok && (host_acc.rd || host_acc.wr);
      if (host_ok && host_acc.rd) begin
        host_rdata_q <= (host_acc.space == SPACE_PROG) ? prog_mem[host_acc.addr] :
                        data_mem[{host_acc.space == SPACE_EXT, host_acc.addr[7:0]}];
      end
      trace_data_q <= (trace_idx <= PTR_LAST) ? trace_mem[trace_idx] : '0;
    end
  end

  // ==================================================================
  // checks

  a_ptr_in_range: assert property (wr_ptr_q <= PTR_LAST)
    else $error("trace pointer past last entry");
  a_trace_wraps: assert property ((trace_we && wr_ptr_q == PTR_LAST) |=> wr_ptr_q == PTR_ZERO)
    else $error("trace pointer did not wrap");
  a_newest_tracks: assert property (trace_we |=> newest_q == $past(wr_ptr_q))
    else $error("newest pointer wrong");
  a_idle_no_write: assert property (!active |=> $stable(wr_ptr_q) && $stable(count_q))
    else $error("trace advanced while halted");
  a_cycle_count_up: assert property ((trace_we && !cnt_clr) |=> cyc_cnt_q == $past(cyc_cnt_q) + 1'b1)
    else $error("cycle counter missed a cycle");
  a_cycle_clear: assert property (cnt_clr |=> cyc_cnt_q == '0)
    else $error("cycle counter not cleared");
  a_step_halts: assert property ((state_q == EMTM_STEP && cyc_stb) |=> !running_q ##1 !active)
    else $error("step did not halt");
  a_xbrk_stops: assert property ((active && x_match) |=> brk_hit_q && !running_q)
    else $error("data write breakpoint missed");
  a_pcbrk_stops: assert property ((active && pc_match) |=> brk_hit_q ##1 state_q == EMTM_IDLE)
    else $error("address breakpoint missed");
  a_block_map: assert property (fetch_stb |=> prog_emu_q == $past(prog_map[fetch_addr[BLK_MSB:BLK_LSB]]))
    else $error("program block map wrong");
  a_count_full: assert property ((trace_we && count_q == COUNT_FULL) |=> count_q == COUNT_FULL)
    else $error("record count overflow");

  c_wrap: cover property (trace_we && wr_ptr_q == PTR_LAST);
  c_step: cover property (state_q == EMTM_STEP ##1 state_q == EMTM_IDLE);
  c_xbrk: cover property (active && x_match);
  c_host_load: cover property (host_pwe ##1 host_ack_q);
endmodule
`default_nettype wire

// >>> emtm_proc_model.sv
// emulated processor model feeding executed instruction cycles
`timescale 1ns/1ns
`default_nettype none
module emtm_proc_model
  import emtm_pkg::*;
(
  // clock
  input wire logic core_clk,
  // pacing from the bench
  input wire logic en,
  input wire logic slow,
  // instruction cycle stream
  output logic cyc_stb,
  output emtm_cyc_t cyc_rec
);
  integer seed = 14; // fixed seed
  logic [11:0] pc_q = 12'h000; // program counter of the program
  initial begin
    cyc_stb = 1'b0;
    cyc_rec = '0;
  end
  always @(posedge core_clk) begin
    cyc_stb <= 1'b0;
    // between cycles the record is not held
    cyc_rec <= ~cyc_rec;
    if (en && (!slow || ($random(seed) & 3) == 0)) begin
      cyc_stb <= 1'b1;
      cyc_rec <= {pc_q, 32'($random(seed))};
      pc_q <= pc_q + 12'h001;
    end
  end
endmodule
`default_nettype wire

// >>> emulator_trace_and_memory_map_tb.sv
// self-checking bench of the trace and memory map block
`timescale 1ns/1ns
`default_nettype none
module emulator_trace_and_memory_map_tb;
  import emtm_pkg::*;
  logic core_clk = 0, rst = 1, error_in = 0, fetch_stb = 0, x_rd = 0, x_wr = 0;
  logic i_wr = 0, ext_map = 0, brk_pc_en = 0, brk_x_en = 0, cnt_clr = 0;
  logic en = 0, slow = 0, live = 0, stepping = 0, cyc_stb;
  logic [11:0] fetch_addr = 0, brk_pc = 0;
  logic [7:0] x_addr = 0, x_wdata = 0, i_addr = 0, i_wdata = 0, brk_xaddr = 0;
  logic [7:0] trace_idx = 0, prog_rdata_q, x_rdata_q, i_rdata_q, host_rdata_q;
  logic [7:0] newest_q, count_q;
  logic [15:0] prog_map = 0, cyc_cnt_q;
  logic prog_emu_q, x_emu_q, host_ack_q, running_q, brk_hit_q;
  logic [43:0] trace_data_q;
  emtm_cyc_t cyc_rec;
  emtm_cmd_t host_cmd = EMTM_CMD_NONE;
  emtm_host_t host_acc = '0;
  logic [43:0] exp_mem [255]; // expected trace contents
  int wp = 0, n_rec = 0, n_fail = 0, n_compared = 0, cycles = 0;
  integer seed = 14;
  emtm_core dut (.core_clk(core_clk), .rst(rst), .cyc_stb(cyc_stb), .cyc_rec(cyc_rec),
    .error_in(error_in), .fetch_stb(fetch_stb), .fetch_addr(fetch_addr),
    .prog_rdata_q(prog_rdata_q), .prog_emu_q(prog_emu_q), .x_rd(x_rd), .x_wr(x_wr),
    .x_addr(x_addr), .x_wdata(x_wdata), .x_rdata_q(x_rdata_q), .x_emu_q(x_emu_q),
    .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .i_rdata_q(i_rdata_q),
    .prog_map(prog_map), .ext_map(ext_map), .brk_pc_en(brk_pc_en), .brk_pc(brk_pc),
    .brk_x_en(brk_x_en), .brk_xaddr(brk_xaddr), .host_cmd(host_cmd),
    .host_acc(host_acc), .cnt_clr(cnt_clr), .host_rdata_q(host_rdata_q),
    .host_ack_q(host_ack_q), .trace_idx(trace_idx), .trace_data_q(trace_data_q),
    .newest_q(newest_q), .count_q(count_q), .cyc_cnt_q(cyc_cnt_q),
    .running_q(running_q), .brk_hit_q(brk_hit_q));
  emtm_proc_model pm (.core_clk(core_clk), .en(en), .slow(slow), .cyc_stb(cyc_stb),
    .cyc_rec(cyc_rec));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // expected ring of records, stops after a step or pc match
  always @(posedge core_clk) begin
    cycles++;
    if (live && cyc_stb) begin
      exp_mem[wp] = cyc_rec;
      wp = (wp == 254) ? 0 : wp + 1;
      n_rec++;
      if (stepping || (brk_pc_en && cyc_rec.pc == brk_pc)) live = 0;
    end
    // timeout counts as a mismatch and ends the run
    if (cycles == 10000) begin
      n_fail++;
      finish_test;
    end
  end
  task chk(input logic [43:0] g, input logic [43:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // newest slot is the one just behind the expected write slot
  function automatic logic [43:0] newest_of(input int w);
    return 44'((w + 254) % 255);
  endfunction
  task hacc(input logic w, input logic [1:0] s, input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_acc <= {w, !w, s, a, d};
    @(posedge core_clk);
    host_acc <= '0;
    #1;
  endtask
  task xacc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {x_wr, x_rd, x_addr, x_wdata} <= {w, !w, a, d};
    @(posedge core_clk);
    {x_wr, x_rd} <= 2'h0;
    #1;
  endtask
  task cmd(input emtm_cmd_t c);
    @(posedge core_clk);
    host_cmd <= c;
    @(posedge core_clk);
    host_cmd <= EMTM_CMD_NONE;
    #1;
  endtask
  task rdt(input logic [7:0] i);
    @(posedge core_clk);
    trace_idx <= i;
    @(posedge core_clk);
    #1;
  endtask
  task wait_stop(input int n, output logic h);
    // the one-cycle stop pulse may already stand on entry
    h = (brk_hit_q === 1'b1);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (brk_hit_q === 1'b1) h = 1;
    end
  endtask
  task finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] d, d2;
    logic [11:0] a;
    logic h;
    repeat (6) @(posedge core_clk);
    rst <= 0;
    // strobes while idle are refused
    en <= 1;
    wait_stop(4, h);
    en <= 0;
    wait_stop(2, h);
    chk(count_q, 0);
    chk(cyc_cnt_q, 0);
    prog_map <= 16'($random(seed));
    for (int b = 0; b < 16; b++) begin
      d = 8'($random(seed));
      a = {b[3:0], 8'($random(seed))};
      hacc(1, SPACE_PROG, a, d);
      chk(host_ack_q, 1);
      @(posedge core_clk);
      {fetch_stb, fetch_addr} <= {1'b1, a};
      @(posedge core_clk);
      fetch_stb <= 0;
      #1;
      chk(prog_rdata_q, d);
      chk(prog_emu_q, prog_map[b]);
    end
    d2 = ~d;
    hacc(1, SPACE_EXT, 12'h05a, d);
    hacc(1, SPACE_INT, 12'h05a, d2);
    hacc(0, SPACE_EXT, 12'h05a, 8'h00);
    chk(host_rdata_q, d);
    ext_map <= 1;
    xacc(0, 8'h5a, 8'h00);
    chk(x_rdata_q, d);
    chk(x_emu_q, 1);
    i_addr <= 8'h5a;
    xacc(0, 8'h5a, 8'h00);
    chk(i_rdata_q, d2);
    // long run wraps the ring, fast then slow
    cmd(EMTM_CMD_GO);
    chk(running_q, 1);
    hacc(1, SPACE_INT, 12'h05a, d);
    chk(host_ack_q, 0);
    live = 1;
    en <= 1;
    repeat (200) @(posedge core_clk);
    slow <= 1;
    repeat (300) @(posedge core_clk);
    en <= 0;
    cmd(EMTM_CMD_STOP);
    live = 0;
    chk(running_q, 0);
    chk(count_q, COUNT_FULL);
    chk(newest_q, newest_of(wp));
    chk(cyc_cnt_q, 44'(n_rec));
    for (int i = 0; i < 256; i++) begin
      rdt(8'(i));
      chk(trace_data_q, (i < 255) ? exp_mem[i] : 44'h0);
    end
    @(posedge core_clk);
    cnt_clr <= 1;
    @(posedge core_clk);
    cnt_clr <= 0;
    #1;
    chk(cyc_cnt_q, 0);
    n_rec = 0;
    // external write breakpoint while running
    {brk_x_en, brk_xaddr, slow} <= {1'b1, 8'h33, 1'b0};
    cmd(EMTM_CMD_GO);
    xacc(1, 8'h32, d2);
    // processor internal write while running
    {i_wr, i_addr, i_wdata} <= {1'b1, 8'h5a, d};
    @(posedge core_clk);
    i_wr <= 0;
    @(posedge core_clk);
    #1;
    chk(i_rdata_q, d);
    xacc(1, 8'h33, d);
    wait_stop(8, h);
    chk(h, 1);
    chk(running_q, 0);
    hacc(0, SPACE_EXT, 12'h032, 8'h00);
    chk(host_rdata_q, d2);
    hacc(0, SPACE_INT, 12'h05a, 8'h00);
    chk(host_rdata_q, d);
    // program counter breakpoint
    {brk_x_en, brk_pc_en, brk_pc} <= {1'b0, 1'b1, pm.pc_q + 12'd20};
    cmd(EMTM_CMD_GO);
    live = 1;
    en <= 1;
    wait_stop(40, h);
    en <= 0;
    chk(h, 1);
    chk(running_q, 0);
    chk(cyc_cnt_q, 44'(n_rec));
    chk(newest_q, newest_of(wp));
    rdt(newest_q);
    chk(trace_data_q[43:32], brk_pc);
    // single step takes exactly one cycle
    brk_pc_en <= 0;
    stepping = 1;
    cmd(EMTM_CMD_STEP);
    live = 1;
    en <= 1;
    wait_stop(6, h);
    en <= 0;
    chk(running_q, 0);
    chk(cyc_cnt_q, 44'(n_rec));
    chk(newest_q, newest_of(wp));
    // error stop keeps the trace
    cmd(EMTM_CMD_GO);
    @(posedge core_clk);
    error_in <= 1;
    @(posedge core_clk);
    error_in <= 0;
    wait_stop(8, h);
    chk(running_q, 0);
    rdt(8'h00);
    chk(trace_data_q, exp_mem[0]);
    finish_test;
  end
endmodule
`default_nettype wire
